//--- dctd_carrier_model.sv
// Carrier source on the demodulation input pin.
// Assumes core_clk paces the half periods; the pin idles low while stopped.
`timescale 1ns/1ns
`default_nettype none
module dctd_carrier_model (
  input wire logic core_clk,
  input wire logic run,
  input wire logic [7:0] half_cycles,
  output var logic carrier_in
);
  logic [7:0] cnt_ff;
  initial carrier_in = 1'b0;
  initial cnt_ff = 8'h00;
  // Starts low so the first edge seen is a rising one
  always @(posedge core_clk) begin
    if (!run) begin
      cnt_ff <= 8'h00;
      carrier_in <= 1'b0;
    end else if (cnt_ff == half_cycles - 8'h01) begin
      cnt_ff <= 8'h00;
      carrier_in <= ~carrier_in;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- dctd_defines.svh
// Offsets, field positions and reset values of the dual counter/timer unit.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef DCTD_DEFINES_SVH
`define DCTD_DEFINES_SVH

`define DCTD_ADDR_SCTL 4'h0
`define DCTD_ADDR_SHCTL 4'h1
`define DCTD_ADDR_LCTL 4'h2
`define DCTD_ADDR_SRLH 4'h3
`define DCTD_ADDR_SRLL 4'h4
`define DCTD_ADDR_LRLU 4'h5
`define DCTD_ADDR_LRLL 4'h6
`define DCTD_ADDR_RCAP 4'h7
`define DCTD_ADDR_FCAP 4'h8
`define DCTD_ADDR_LCAPU 4'h9
`define DCTD_ADDR_LCAPL 4'hA

// Short and long control fields
`define DCTD_BIT_EN 7
`define DCTD_BIT_SP 6
`define DCTD_BIT_TO 5
`define DCTD_BIT_CIE 2
`define DCTD_BIT_TIE 1
`define DCTD_BIT_LCAP 0

// Shared control fields
`define DCTD_BIT_DEMOD 6
`define DCTD_BIT_EDGE_HI 5
`define DCTD_BIT_EDGE_LO 4
`define DCTD_BIT_PP_HI 3
`define DCTD_BIT_PP_LO 2
`define DCTD_BIT_SINIT 1
`define DCTD_BIT_LINIT 0

`define DCTD_PP_ON 2'h2
`define DCTD_REG_RESET 8'h00
`define DCTD_DEMOD_RELOAD 8'hFF

`endif

//--- dctd_edge_detect.sv
// Synchroniser and edge detector for the demodulation carrier input.
// Assumes carrier_in is asynchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module dctd_edge_detect (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic carrier_in,
  dctd_edge_if.src edge_ev
);
  logic sync1_ff;
  logic sync2_ff;
  logic last_ff;

  // Two stages before any logic looks at the pin
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      sync1_ff <= carrier_in;
      sync2_ff <= sync1_ff;
      last_ff <= sync2_ff;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_ev.rise <= 1'b0;
      edge_ev.fall <= 1'b0;
    end else begin
      edge_ev.rise <= sync2_ff & ~last_ff;
      edge_ev.fall <= ~sync2_ff & last_ff;
    end
  end
endmodule
`default_nettype wire

//--- dctd_edge_if.sv
// Carries carrier edge events from the edge detector to the counters.
// Assumes both ends run on core_clk.
`timescale 1ns/1ns
`default_nettype none
interface dctd_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface
`default_nettype wire

//--- dctd_pkg.sv
// Types of the dual counter/timer unit.
// Assumes the constants header for field positions.
package dctd_pkg;
  typedef enum logic [1:0] {
    DCTD_ST_IDLE = 2'b00,
    DCTD_ST_WAIT = 2'b01,
    DCTD_ST_RUN = 2'b10
  } dctd_short_state_t;
endpackage

//--- dctd_timer_top.sv
// Paired short and long down-counters: transmit, demodulation and ping-pong use.
// Assumes a one-cycle register port and an asynchronous carrier input pin.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "dctd_defines.svh"
module dctd_timer_top #(
  parameter int SHORT_W = 8,
  parameter int LONG_W = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic carrier_in,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  output logic short_counter_output_ff,
  output logic long_counter_output_ff,
  output logic short_irq_ff,
  output logic long_irq_ff
);
  // Byte-wide register port ties the counters to these widths
  if (SHORT_W != 8 || LONG_W != 16) begin : g_width_check
    $error("dctd_timer_top supports only SHORT_W 8 and LONG_W 16");
  end

  function automatic logic edge_qual(input logic [1:0] sel, input logic r, input logic f);
    edge_qual = (sel[0] & r) | (sel[1] & f);
  endfunction

  dctd_edge_if edge_ev ();
  dctd_edge_detect u_edge (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .carrier_in(carrier_in),
    .edge_ev(edge_ev)
  );

  // Software visible control
  logic s_en_ff, s_single_ff, s_to_ff, s_cie_ff, s_tie_ff;
  logic l_en_ff, l_mark_ff, l_to_ff, l_cie_ff, l_tie_ff, l_cap_flag_ff;
  logic demod_ff, s_init_ff, l_init_ff, rise_flag_ff, fall_flag_ff;
  logic [1:0] edge_sel_ff, pp_sel_ff;
  logic [7:0] short_reload_high_ff, short_reload_low_ff, long_reload_upper_ff, long_reload_lower_ff;
  logic [7:0] rising_edge_capture_ff, falling_edge_capture_ff;
  logic [LONG_W-1:0] long_capture_ff;

  // Counter state
  dctd_pkg::dctd_short_state_t s_state_ff;
  logic [SHORT_W-1:0] short_down_counter_ff;
  logic [LONG_W-1:0] long_down_counter_ff;
  logic s_en_q_ff, l_en_q_ff, s_first_ff, l_run_ff, l_arm_ff;

  logic wr_sctl, wr_shctl, wr_lctl;
  logic s_start, l_start, pp_on, edge_q, rise_q, fall_q;
  logic s_run, s_tc, s_to_set, s_edge_take, l_tc, l_edge_take, l_time_cap;

  assign wr_sctl = reg_wr && (reg_addr == `DCTD_ADDR_SCTL);
  assign wr_shctl = reg_wr && (reg_addr == `DCTD_ADDR_SHCTL);
  assign wr_lctl = reg_wr && (reg_addr == `DCTD_ADDR_LCTL);

  assign s_start = s_en_ff && !s_en_q_ff;
  assign l_start = l_en_ff && !l_en_q_ff;
  assign pp_on = (pp_sel_ff == `DCTD_PP_ON) && !demod_ff;
  assign rise_q = edge_sel_ff[0] & edge_ev.rise;
  assign fall_q = edge_sel_ff[1] & edge_ev.fall;
  assign edge_q = demod_ff && edge_qual(edge_sel_ff, edge_ev.rise, edge_ev.fall);
  assign s_run = (s_state_ff == dctd_pkg::DCTD_ST_RUN) && s_en_ff;
  assign s_edge_take = s_run && edge_q;
  // Terminal count is the step from one to zero, so a wrap from zero never counts
  assign s_tc = s_run && !s_edge_take && (short_down_counter_ff == SHORT_W'(1));
  assign s_to_set = s_tc && (demod_ff || s_single_ff || pp_on || !s_first_ff);
  assign l_edge_take = demod_ff && l_run_ff && l_en_ff && edge_q && (!l_mark_ff || l_arm_ff);
  assign l_tc = l_run_ff && l_en_ff && !l_edge_take && (long_down_counter_ff == LONG_W'(1));
  assign l_time_cap = demod_ff && l_run_ff && l_en_ff && l_mark_ff && s_tc && !l_edge_take;

  // Short control register; hardware enable changes override the write
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_en_ff <= 1'b0;
      s_single_ff <= 1'b0;
      s_cie_ff <= 1'b0;
      s_tie_ff <= 1'b0;
      s_to_ff <= 1'b0;
    end else begin
      if (wr_sctl) begin
        s_en_ff <= reg_wdata[`DCTD_BIT_EN];
        s_single_ff <= reg_wdata[`DCTD_BIT_SP];
        s_cie_ff <= reg_wdata[`DCTD_BIT_CIE];
        s_tie_ff <= reg_wdata[`DCTD_BIT_TIE];
      end
      if (s_tc && !demod_ff && (s_single_ff || pp_on))
        s_en_ff <= 1'b0;
      if (l_tc && pp_on)
        s_en_ff <= 1'b1;
      // Set wins over a clear in the same cycle
      if (s_to_set)
        s_to_ff <= 1'b1;
      else if (wr_sctl && reg_wdata[`DCTD_BIT_TO])
        s_to_ff <= 1'b0;
    end
  end

  // Shared control register and edge flags
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      demod_ff <= 1'b0;
      edge_sel_ff <= 2'h0;
      pp_sel_ff <= 2'h0;
      s_init_ff <= 1'b0;
      l_init_ff <= 1'b0;
      rise_flag_ff <= 1'b0;
      fall_flag_ff <= 1'b0;
    end else begin
      if (wr_shctl) begin
        demod_ff <= reg_wdata[`DCTD_BIT_DEMOD];
        edge_sel_ff <= reg_wdata[`DCTD_BIT_EDGE_HI:`DCTD_BIT_EDGE_LO];
        pp_sel_ff <= reg_wdata[`DCTD_BIT_PP_HI:`DCTD_BIT_PP_LO];
        s_init_ff <= reg_wdata[`DCTD_BIT_SINIT];
        l_init_ff <= reg_wdata[`DCTD_BIT_LINIT];
      end
      if (s_edge_take && rise_q)
        rise_flag_ff <= 1'b1;
      else if (wr_shctl && demod_ff && reg_wdata[`DCTD_BIT_SINIT])
        rise_flag_ff <= 1'b0;
      if (s_edge_take && fall_q)
        fall_flag_ff <= 1'b1;
      else if (wr_shctl && demod_ff && reg_wdata[`DCTD_BIT_LINIT])
        fall_flag_ff <= 1'b0;
    end
  end

  // Long control register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      l_en_ff <= 1'b0;
      l_mark_ff <= 1'b0;
      l_cie_ff <= 1'b0;
      l_tie_ff <= 1'b0;
      l_to_ff <= 1'b0;
      l_cap_flag_ff <= 1'b0;
      l_arm_ff <= 1'b0;
    end else begin
      if (wr_lctl) begin
        l_en_ff <= reg_wdata[`DCTD_BIT_EN];
        l_mark_ff <= reg_wdata[`DCTD_BIT_SP];
        l_cie_ff <= reg_wdata[`DCTD_BIT_CIE];
        l_tie_ff <= reg_wdata[`DCTD_BIT_TIE];
      end
      if (l_tc && !demod_ff && (l_mark_ff || pp_on))
        l_en_ff <= 1'b0;
      if (s_tc && !demod_ff && pp_on)
        l_en_ff <= 1'b1;
      if (l_tc)
        l_to_ff <= 1'b1;
      else if (wr_lctl && reg_wdata[`DCTD_BIT_TO])
        l_to_ff <= 1'b0;
      if (l_edge_take || l_time_cap)
        l_cap_flag_ff <= 1'b1;
      else if (wr_lctl && reg_wdata[`DCTD_BIT_LCAP])
        l_cap_flag_ff <= 1'b0;
      // Only a fresh zero-to-one write of the mark select arms one capture
      if (wr_lctl && reg_wdata[`DCTD_BIT_SP] && !l_mark_ff)
        l_arm_ff <= 1'b1;
      else if (l_edge_take)
        l_arm_ff <= 1'b0;
    end
  end

  // Reload values: stored at once, used only when a load happens
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      short_reload_high_ff <= `DCTD_REG_RESET;
      short_reload_low_ff <= `DCTD_REG_RESET;
      long_reload_upper_ff <= `DCTD_REG_RESET;
      long_reload_lower_ff <= `DCTD_REG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `DCTD_ADDR_SRLH)
        short_reload_high_ff <= reg_wdata;
      if (reg_addr == `DCTD_ADDR_SRLL)
        short_reload_low_ff <= reg_wdata;
      if (reg_addr == `DCTD_ADDR_LRLU)
        long_reload_upper_ff <= reg_wdata;
      if (reg_addr == `DCTD_ADDR_LRLL)
        long_reload_lower_ff <= reg_wdata;
    end
  end

  // Enable history; a hardware set restarts a counter exactly like software does
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_en_q_ff <= 1'b0;
      l_en_q_ff <= 1'b0;
    end else begin
      s_en_q_ff <= s_en_ff;
      l_en_q_ff <= l_en_ff;
    end
  end

  // Short counter sequencing
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_state_ff <= dctd_pkg::DCTD_ST_IDLE;
    end else begin
      unique case (s_state_ff)
        dctd_pkg::DCTD_ST_IDLE: begin
          if (s_start)
            s_state_ff <= demod_ff ? dctd_pkg::DCTD_ST_WAIT : dctd_pkg::DCTD_ST_RUN;
        end
        dctd_pkg::DCTD_ST_WAIT: begin
          if (!s_en_ff)
            s_state_ff <= dctd_pkg::DCTD_ST_IDLE;
          else if (edge_q)
            s_state_ff <= dctd_pkg::DCTD_ST_RUN;
        end
        dctd_pkg::DCTD_ST_RUN: begin
          if (!s_en_ff || (s_tc && !demod_ff && (s_single_ff || pp_on)))
            s_state_ff <= dctd_pkg::DCTD_ST_IDLE;
        end
        default: s_state_ff <= dctd_pkg::DCTD_ST_IDLE;
      endcase
    end
  end

  // Short counter datapath and output pin
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      short_down_counter_ff <= '0;
      short_counter_output_ff <= 1'b0;
      s_first_ff <= 1'b0;
    end else begin
      if (s_start && !demod_ff) begin
        short_counter_output_ff <= s_init_ff;
        short_down_counter_ff <= s_init_ff ? short_reload_high_ff : short_reload_low_ff;
        s_first_ff <= 1'b1;
      end else if (s_state_ff == dctd_pkg::DCTD_ST_WAIT && s_en_ff && edge_q) begin
        short_down_counter_ff <= `DCTD_DEMOD_RELOAD;
      end else if (s_run) begin
        if (s_edge_take)
          short_down_counter_ff <= `DCTD_DEMOD_RELOAD;
        else if (s_tc && !demod_ff && !s_single_ff && !pp_on)
          short_down_counter_ff <= short_counter_output_ff ? short_reload_low_ff : short_reload_high_ff;
        else
          short_down_counter_ff <= short_down_counter_ff - 1'b1;
        if (s_tc && !demod_ff)
          short_counter_output_ff <= ~short_counter_output_ff;
        if (s_tc)
          s_first_ff <= 1'b0;
      end
    end
  end

  // Edge captures hold the complement, so a larger value means a longer interval; the mark-time capture holds the raw count
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rising_edge_capture_ff <= `DCTD_REG_RESET;
      falling_edge_capture_ff <= `DCTD_REG_RESET;
      long_capture_ff <= '0;
    end else begin
      if (s_edge_take && rise_q)
        rising_edge_capture_ff <= ~short_down_counter_ff;
      if (s_edge_take && fall_q)
        falling_edge_capture_ff <= ~short_down_counter_ff;
      if (l_edge_take)
        long_capture_ff <= ~long_down_counter_ff;
      else if (l_time_cap)
        long_capture_ff <= long_down_counter_ff;
    end
  end

  // Long counter datapath and output pin
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      long_down_counter_ff <= '0;
      long_counter_output_ff <= 1'b0;
      l_run_ff <= 1'b0;
    end else begin
      if (l_start) begin
        l_run_ff <= 1'b1;
        long_down_counter_ff <= {long_reload_upper_ff, long_reload_lower_ff};
        if (!demod_ff)
          long_counter_output_ff <= l_init_ff;
      end else if (!l_en_ff) begin
        l_run_ff <= 1'b0;
      end else if (l_run_ff) begin
        if (l_edge_take || (l_tc && !demod_ff && !l_mark_ff && !pp_on))
          long_down_counter_ff <= {long_reload_upper_ff, long_reload_lower_ff};
        else
          long_down_counter_ff <= long_down_counter_ff - 1'b1;
        if (l_tc && !demod_ff)
          long_counter_output_ff <= ~long_counter_output_ff;
        if (l_tc && !demod_ff && (l_mark_ff || pp_on))
          l_run_ff <= 1'b0;
      end
    end
  end

  // Interrupt requests, one per counter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      short_irq_ff <= 1'b0;
      long_irq_ff <= 1'b0;
    end else begin
      short_irq_ff <= (s_to_ff && s_tie_ff) || ((rise_flag_ff || fall_flag_ff) && s_cie_ff);
      long_irq_ff <= (l_to_ff && l_tie_ff) || (l_cap_flag_ff && l_cie_ff);
    end
  end

  // Read port: data stands in the cycle after the strobe only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_ff <= `DCTD_REG_RESET;
    end else if (!reg_rd) begin
      reg_rdata_ff <= `DCTD_REG_RESET;
    end else begin
      unique case (reg_addr)
        `DCTD_ADDR_SCTL: reg_rdata_ff <= {s_en_ff, s_single_ff, s_to_ff, 2'b00, s_cie_ff, s_tie_ff, 1'b0};
        `DCTD_ADDR_SHCTL: reg_rdata_ff <= {1'b0, demod_ff, edge_sel_ff, pp_sel_ff,
                                           demod_ff ? {rise_flag_ff, fall_flag_ff} : {s_init_ff, l_init_ff}};
        `DCTD_ADDR_LCTL: reg_rdata_ff <= {l_en_ff, l_mark_ff, l_to_ff, 2'b00, l_cie_ff, l_tie_ff, l_cap_flag_ff};
        `DCTD_ADDR_SRLH: reg_rdata_ff <= short_reload_high_ff;
        `DCTD_ADDR_SRLL: reg_rdata_ff <= short_reload_low_ff;
        `DCTD_ADDR_LRLU: reg_rdata_ff <= long_reload_upper_ff;
        `DCTD_ADDR_LRLL: reg_rdata_ff <= long_reload_lower_ff;
        `DCTD_ADDR_RCAP: reg_rdata_ff <= rising_edge_capture_ff;
        `DCTD_ADDR_FCAP: reg_rdata_ff <= falling_edge_capture_ff;
        `DCTD_ADDR_LCAPU: reg_rdata_ff <= long_capture_ff[15:8];
        `DCTD_ADDR_LCAPL: reg_rdata_ff <= long_capture_ff[7:0];
        default: reg_rdata_ff <= `DCTD_REG_RESET;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence tx_start_s;
    s_start && !demod_ff;
  endsequence

  sequence pp_hand_s;
    pp_on && s_tc ##1 (!s_en_ff && l_en_ff);
  endsequence

  a_start_level: assert property (tx_start_s |=> short_counter_output_ff == $past(s_init_ff))
    else $error("short output did not take its initial level");
  a_start_count: assert property (tx_start_s |=> short_down_counter_ff ==
      ($past(s_init_ff) ? $past(short_reload_high_ff) : $past(short_reload_low_ff)))
    else $error("short counter loaded the wrong reload value");
  a_single_stop: assert property (s_tc && s_single_ff && !demod_ff && !pp_on |=>
      !s_en_ff && s_to_ff && short_counter_output_ff != $past(short_counter_output_ff))
    else $error("single-pass terminal count handled wrongly");
  a_modn_first: assert property (s_tc && !s_single_ff && !demod_ff && !pp_on && s_first_ff && !s_to_ff
      |=> !s_to_ff)
    else $error("first modulo-N terminal count set timeout");
  a_modn_reload: assert property (s_tc && !s_single_ff && !demod_ff && !pp_on |=> short_down_counter_ff ==
      (short_counter_output_ff ? $past(short_reload_high_ff) : $past(short_reload_low_ff)))
    else $error("modulo-N reload does not follow output level");
  a_wrap_quiet: assert property (s_run && !demod_ff && short_down_counter_ff == '0 && !s_to_ff
      |=> short_down_counter_ff == 8'hFF && !s_to_ff)
    else $error("wrap from zero handled as timeout");
  a_rise_capture: assert property (s_edge_take && rise_q |=> rising_edge_capture_ff ==
      ~$past(short_down_counter_ff) && rise_flag_ff && short_down_counter_ff == 8'hFF)
    else $error("rising edge capture wrong");
  a_demod_timeout: assert property (s_tc && demod_ff |=> s_to_ff ##1
      (short_down_counter_ff == 8'hFF || $past(s_edge_take) || !s_run))
    else $error("demodulation timeout did not continue from FFh");
  a_mark_hold: assert property (l_time_cap |=> l_cap_flag_ff &&
      long_capture_ff == $past(long_down_counter_ff) &&
      (long_down_counter_ff == $past(long_down_counter_ff) - 16'h0001 || !l_en_ff))
    else $error("mark-time capture wrong or reloaded");
  a_pp_handover: assert property (pp_hand_s |=> ##1 l_run_ff && long_counter_output_ff == $past(l_init_ff))
    else $error("ping-pong hand-over to long counter failed");
  a_short_irq: assert property (s_to_ff && s_tie_ff |=> short_irq_ff)
    else $error("short interrupt not raised");
endmodule
`default_nettype wire

//--- tb_dual_counter_timer_transmit_demod.sv
// Self-checking bench: single-pass, modulo-N, demodulation and ping-pong runs.
// Assumes one 50 MHz clock and the carrier model on the input pin.
`timescale 1ns/1ns
`default_nettype none
`include "dctd_defines.svh"
module tb_dual_counter_timer_transmit_demod;
  logic core_clk, sys_rst, reg_wr, reg_rd, rd_seen, run;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_ff, half;
  logic s_out, l_out, s_irq, l_irq, carrier_in;
  logic [7:0] exp_q[$], msk_q[$];
  int num_errors, checks_done, cyc, t0, t1, t2, hi_v, lo_v, lo2;
  dctd_timer_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .carrier_in(carrier_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .short_counter_output_ff(s_out),
    .long_counter_output_ff(l_out), .short_irq_ff(s_irq), .long_irq_ff(l_irq));
  dctd_carrier_model carrier (.core_clk(core_clk), .run(run), .half_cycles(half),
    .carrier_in(carrier_in));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    rd_seen <= reg_rd;
    cyc <= cyc + 1;
  end
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Read data lives only in the cycle after the strobe, so it is taken mid-cycle
  always @(negedge core_clk) begin
    if (rd_seen === 1'b1) begin
      cmp({8'h00, reg_rdata_ff & msk_q[0]}, {8'h00, exp_q[0]});
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic chk(ref logic s, input logic v);
    @(negedge core_clk);
    cmp({15'h0000, s}, {15'h0000, v});
  endtask
  // Bounded wait; a miss shows up as one failed compare
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (s !== v && n < 1000);
    cmp({15'h0000, s}, {15'h0000, v});
  endtask
  task automatic finish_test;
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    num_errors++;
    finish_test();
  end
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    rd_seen = 1'b0;
    run = 1'b0;
    half = 8'h15;
    cyc = 0;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(32'h654e_985a));
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(`DCTD_ADDR_SCTL, 8'hFF, 8'h00);
    rd(4'hB, 8'hFF, 8'h00);
    wr(`DCTD_ADDR_SRLL, 8'h03);
    wr(`DCTD_ADDR_SCTL, 8'hC2);
    wait_for(s_out, 1'b1);
    rd(`DCTD_ADDR_SCTL, 8'hFF, 8'h62);
    chk(s_irq, 1'b1);
    wr(`DCTD_ADDR_SCTL, 8'h20);
    rd(`DCTD_ADDR_SCTL, 8'hFF, 8'h00);
    chk(s_irq, 1'b0);
    // Zero start wraps through FFh, so the stop comes a full 256 counts after the load
    wr(`DCTD_ADDR_SRLL, 8'h00);
    wr(`DCTD_ADDR_SCTL, 8'hC0);
    t0 = cyc;
    repeat (20) @(posedge core_clk);
    rd(`DCTD_ADDR_SCTL, 8'h20, 8'h00);
    wait_for(s_out, 1'b1);
    t1 = cyc;
    cmp(16'(t1 - t0), 16'h0102);
    wr(`DCTD_ADDR_SCTL, 8'h20);
    // Phases long enough that the mid-phase register traffic ends before the next load
    hi_v = $urandom_range(40, 12);
    lo_v = $urandom_range(40, 12);
    lo2 = $urandom_range(40, 12);
    wr(`DCTD_ADDR_SRLH, hi_v[7:0]);
    wr(`DCTD_ADDR_SRLL, lo_v[7:0]);
    wr(`DCTD_ADDR_SCTL, 8'h82);
    // Output takes its initial level one edge after the enable lands
    @(posedge core_clk);
    chk(s_out, 1'b0);
    wait_for(s_out, 1'b1);
    t0 = cyc;
    rd(`DCTD_ADDR_SCTL, 8'h20, 8'h00);
    chk(s_irq, 1'b0);
    wr(`DCTD_ADDR_SRLL, lo2[7:0]);
    wait_for(s_out, 1'b0);
    t1 = cyc;
    rd(`DCTD_ADDR_SCTL, 8'h20, 8'h20);
    wait_for(s_out, 1'b1);
    t2 = cyc;
    cmp(16'((t2 - t1) - (t1 - t0)), 16'(lo2 - hi_v));
    wr(`DCTD_ADDR_SCTL, 8'h00);
    wr(`DCTD_ADDR_SCTL, 8'h20);
    wr(`DCTD_ADDR_SRLH, 8'hFF);
    wr(`DCTD_ADDR_SRLL, 8'hFF);
    wr(`DCTD_ADDR_SHCTL, 8'h50);
    // Long counter runs at once; its first zero comes well inside the idle wait
    wr(`DCTD_ADDR_LRLL, 8'h40);
    wr(`DCTD_ADDR_LCTL, 8'hC2);
    wr(`DCTD_ADDR_SCTL, 8'h84);
    // Idle longer than a full FFh count: any counting would raise timeout
    repeat (300) @(posedge core_clk);
    rd(`DCTD_ADDR_SCTL, 8'h20, 8'h00);
    rd(`DCTD_ADDR_LCTL, 8'h21, 8'h20);
    chk(l_irq, 1'b1);
    run <= 1'b1;
    wait_for(s_irq, 1'b1);
    rd(`DCTD_ADDR_RCAP, 8'hFC, 8'h28);
    rd(`DCTD_ADDR_SHCTL, 8'h02, 8'h02);
    rd(`DCTD_ADDR_LCTL, 8'h01, 8'h01);
    wr(`DCTD_ADDR_LCTL, 8'hC3);
    run <= 1'b0;
    repeat (300) @(posedge core_clk);
    rd(`DCTD_ADDR_SCTL, 8'h20, 8'h20);
    // Raw value shortly after the FFFFh wrap: a complemented capture would read 00h
    rd(`DCTD_ADDR_LCTL, 8'h01, 8'h01);
    rd(`DCTD_ADDR_LCAPU, 8'hFF, 8'hFF);
    wr(`DCTD_ADDR_SCTL, 8'h00);
    wr(`DCTD_ADDR_LCTL, 8'h21);
    wr(`DCTD_ADDR_SHCTL, 8'h00);
    wr(`DCTD_ADDR_SCTL, 8'h60);
    wr(`DCTD_ADDR_SRLL, 8'h10);
    wr(`DCTD_ADDR_LRLU, 8'h00);
    wr(`DCTD_ADDR_LRLL, 8'h0A);
    wr(`DCTD_ADDR_LCTL, 8'h62);
    wr(`DCTD_ADDR_SHCTL, 8'h08);
    wr(`DCTD_ADDR_SCTL, 8'hC0);
    wait_for(l_out, 1'b1);
    chk(l_irq, 1'b1);
    rd(`DCTD_ADDR_SCTL, 8'hA0, 8'hA0);
    rd(`DCTD_ADDR_LCTL, 8'hA0, 8'h20);
    wr(`DCTD_ADDR_SHCTL, 8'h00);
    repeat (100) @(posedge core_clk);
    rd(`DCTD_ADDR_LCTL, 8'h80, 8'h00);
    repeat (3) @(posedge core_clk);
    finish_test();
  end
endmodule
`default_nettype wire
